// file: logic/sbr_pkg.sv
// Shared constants, command codes and timing counts for the SDRAM bank and refresh link
package sbr_pkg;
   localparam int ROW_W = 13;
   localparam int BANKS = 4;
   localparam int PSEL_BIT = 10;
   localparam int CNT_W = 6;
   localparam int CLK_NS = 10;
   // Clk cycles per half period of the link clock made by the controller
   localparam int LINK_HALF = 4;
   localparam int LINK_NS = 2 * LINK_HALF * CLK_NS;

   // Least times in ns, self refresh exit floor in link clocks; plain defaults, set per memory grade
   localparam int ROW_PRE_NS = 20;
   localparam int ROW_COL_NS = 20;
   localparam int ROW_CYC_NS = 70;
   localparam int ROW_ROW_NS = 15;
   localparam int ROW_ACT_NS = 45;
   localparam int SR_EXIT_NS = 120;
   localparam int REF_CYC_NS = 80;
   localparam int SR_EXIT_MIN_CK = 2;

   // Least time to link clocks: round up, never below one
   function automatic int ns_to_ck(input int ns);
      int ck;
      ck = (ns + LINK_NS - 1) / LINK_NS;
      return (ck < 1) ? 1 : ck;
   endfunction

   localparam logic [CNT_W-1:0] ROW_PRE_CK = CNT_W'(ns_to_ck(ROW_PRE_NS));
   localparam logic [CNT_W-1:0] ROW_COL_CK = CNT_W'(ns_to_ck(ROW_COL_NS));
   localparam logic [CNT_W-1:0] ROW_CYC_CK = CNT_W'(ns_to_ck(ROW_CYC_NS));
   localparam logic [CNT_W-1:0] ROW_ROW_CK = CNT_W'(ns_to_ck(ROW_ROW_NS));
   localparam logic [CNT_W-1:0] ROW_ACT_CK = CNT_W'(ns_to_ck(ROW_ACT_NS));
   localparam logic [CNT_W-1:0] REF_CYC_CK = CNT_W'(ns_to_ck(REF_CYC_NS));
   localparam logic [CNT_W-1:0] SR_EXIT_CK =
      CNT_W'((ns_to_ck(SR_EXIT_NS) < SR_EXIT_MIN_CK) ? SR_EXIT_MIN_CK : ns_to_ck(SR_EXIT_NS));

   // Longest refresh spacing, rounded down to clk cycles
   localparam int REF_INTERVAL_PS = 7812500;
   localparam int REFI_W = 10;
   localparam logic [REFI_W-1:0] REFI_CYC = REFI_W'(REF_INTERVAL_PS / (CLK_NS * 1000));

   // Strobe patterns {row, column, write}, chip select low
   localparam logic [2:0] PAT_NOP = 3'h7;
   localparam logic [2:0] PAT_ACT = 3'h3;
   localparam logic [2:0] PAT_RD = 3'h5;
   localparam logic [2:0] PAT_WR = 3'h4;
   localparam logic [2:0] PAT_STOP = 3'h6;
   localparam logic [2:0] PAT_PRE = 3'h2;
   localparam logic [2:0] PAT_REF = 3'h1;

   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREALL,
      CMD_STOP, CMD_SELF, CMD_DEEP, CMD_WAKE
   } sbr_cmd_t;
endpackage

// file: logic/sbr_link_if.sv
// Command pins between the memory controller and the SDRAM
`timescale 1ns/1ps
`default_nettype none
interface sbr_link_if;
   logic sdram_clk;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] ba;
   logic [sbr_pkg::ROW_W-1:0] addr;

   modport ctrl (output sdram_clk, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
   modport mem (input sdram_clk, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface
`default_nettype wire

// file: logic/sbr_mem.sv
// SDRAM end: command decode, bank state, auto precharge, refresh counter, power states
`timescale 1ns/1ps
`default_nettype none
module sbr_mem #(
   parameter int BURST_LEN = 4,
   parameter int SR_OSC_CYC = 781
) (
   input wire logic clk_in,
   input wire logic rst_in,
   sbr_link_if.mem link,
   output logic [3:0] bank_open_out,
   output logic burst_active_out,
   output logic burst_cut_out,
   output logic [sbr_pkg::ROW_W-1:0] ref_row_out,
   output logic self_ref_out,
   output logic deep_pd_out,
   output logic data_lost_out
);
   localparam int RW = sbr_pkg::ROW_W;
   localparam int PW = 8 + RW;
   localparam int BW = $clog2(BURST_LEN + 1);

   typedef enum logic [1:0] {MD_RUN, MD_SELF, MD_DEEP} sbr_mode_t;

   logic [PW-1:0] s1_r, s2_r;
   logic prev_r;
   sbr_mode_t mode_r, mode_nxt;
   logic [3:0] open_r, open_nxt;
   logic [RW-1:0] row_r [4];
   logic [RW-1:0] row_nxt [4];
   logic [BW-1:0] burst_r, burst_nxt;
   logic [1:0] bbank_r, bbank_nxt;
   logic ap_r, ap_nxt;
   logic cut_r, cut_nxt;
   logic [RW-1:0] rrow_r, rrow_nxt;
   logic [15:0] osc_r, osc_nxt;
   logic lost_r, lost_nxt;
   logic p_clk, p_cke, p_cs_n, rise;
   logic [2:0] p_pat;
   logic [1:0] p_ba;
   logic [RW-1:0] p_addr;

   // Synchronised pin fields; all share one latency so they stay aligned
   assign {p_clk, p_cke, p_cs_n, p_pat, p_ba, p_addr} = s2_r;
   assign rise = p_clk & ~prev_r;

   // Next state of banks, bursts and power mode
   always_comb begin
      mode_nxt = mode_r;
      open_nxt = open_r;
      row_nxt = row_r;
      burst_nxt = burst_r;
      bbank_nxt = bbank_r;
      ap_nxt = ap_r;
      cut_nxt = 1'b0;
      rrow_nxt = rrow_r;
      osc_nxt = osc_r;
      lost_nxt = lost_r;
      unique case (mode_r)
         MD_RUN: begin
            if (rise) begin
               // Burst runs down; auto precharge closes its bank at the end
               if (burst_r != '0) begin
                  burst_nxt = burst_r - BW'(1);
                  if (burst_r == BW'(1) && ap_r) begin
                     open_nxt[bbank_r] = 1'b0;
                  end
               end
               if (!p_cs_n && p_cke) begin
                  case (p_pat)
                     sbr_pkg::PAT_ACT: begin
                        if (!open_r[p_ba]) begin
                           open_nxt[p_ba] = 1'b1;
                           row_nxt[p_ba] = p_addr;
                        end
                     end
                     sbr_pkg::PAT_RD, sbr_pkg::PAT_WR: begin
                        // Access to an idle bank is dropped
                        if (open_r[p_ba]) begin
                           burst_nxt = BW'(BURST_LEN);
                           bbank_nxt = p_ba;
                           ap_nxt = p_addr[sbr_pkg::PSEL_BIT];
                        end
                     end
                     sbr_pkg::PAT_PRE: begin
                        if (p_addr[sbr_pkg::PSEL_BIT]) begin
                           open_nxt = 4'h0;
                        end else begin
                           open_nxt[p_ba] = 1'b0;
                        end
                     end
                     sbr_pkg::PAT_STOP: begin
                        // Only the latest burst is tracked, so only it is cut
                        if (burst_r != '0 && !ap_r) begin
                           burst_nxt = '0;
                           cut_nxt = 1'b1;
                        end
                     end
                     sbr_pkg::PAT_REF: begin
                        rrow_nxt = rrow_r + RW'(1);
                     end
                     default: begin
                     end
                  endcase
               end else if (!p_cs_n) begin
                  case (p_pat)
                     sbr_pkg::PAT_REF: begin
                        mode_nxt = MD_SELF;
                        osc_nxt = '0;
                        burst_nxt = '0;
                     end
                     sbr_pkg::PAT_STOP: begin
                        if (open_r == 4'h0) begin
                           mode_nxt = MD_DEEP;
                           lost_nxt = 1'b1;
                           burst_nxt = '0;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         MD_SELF: begin
            // Own timer, independent of the link clock, which may stop
            if (osc_r == 16'(SR_OSC_CYC - 1)) begin
               osc_nxt = '0;
               rrow_nxt = rrow_r + RW'(1);
            end else begin
               osc_nxt = osc_r + 16'h1;
            end
            if (p_cke) begin
               mode_nxt = MD_RUN;
            end
         end
         MD_DEEP: begin
            if (p_cke) begin
               mode_nxt = MD_RUN;
            end
         end
      endcase
   end

   // Two-stage pin synchroniser and state registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_r <= {1'b0, 1'b0, 1'b1, 3'h7, 2'h0, {RW{1'b0}}};
         s2_r <= {1'b0, 1'b0, 1'b1, 3'h7, 2'h0, {RW{1'b0}}};
         prev_r <= 1'b0;
         mode_r <= MD_RUN;
         open_r <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            row_r[i] <= '0;
         end
         burst_r <= '0;
         bbank_r <= 2'h0;
         ap_r <= 1'b0;
         cut_r <= 1'b0;
         rrow_r <= '0;
         osc_r <= 16'h0;
         lost_r <= 1'b0;
      end else begin
         s1_r <= {link.sdram_clk, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                  link.ba, link.addr};
         s2_r <= s1_r;
         prev_r <= p_clk;
         mode_r <= mode_nxt;
         open_r <= open_nxt;
         row_r <= row_nxt;
         burst_r <= burst_nxt;
         bbank_r <= bbank_nxt;
         ap_r <= ap_nxt;
         cut_r <= cut_nxt;
         rrow_r <= rrow_nxt;
         osc_r <= osc_nxt;
         lost_r <= lost_nxt;
      end
   end

   assign bank_open_out = open_r;
   assign burst_active_out = (burst_r != '0);
   assign burst_cut_out = cut_r;
   assign ref_row_out = rrow_r;
   assign self_ref_out = (mode_r == MD_SELF);
   assign deep_pd_out = (mode_r == MD_DEEP);
   assign data_lost_out = lost_r;
endmodule
`default_nettype wire

// file: logic/sbr_ctrl.sv
// Memory controller end: link clock, bank bookkeeping, timing guards and refresh scheduling
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Strobes plus clock enable select the command
// - Precharge select bit picks one or all
// - Select high closes all, low one bank
// - No activate before row precharge time elapses
// - Precharged bank idle; activate before access
// - Select bit on access gives auto precharge
// - Hold bank after auto precharge completes fully
// - Terminate cuts only the latest burst
// - Refresh only with banks idle, precharge met
// - Refresh row comes from internal counter
// - Spread refreshes, one per refresh interval
// - Self refresh: clock enable low, rest ignored
// - Self refresh runs on internal timing alone
// - Stay in self refresh row active time
// - Exit: clock, enable high, then NOPs
// - Resume refreshes within interval after exit
// - Deep power-down only with all banks idle
// - Deep power-down loses data, exits on enable
// - Row to column delay before access
// - Same-bank activates spaced by row cycle time
// - Cross-bank activates spaced by row-to-row delay
module sbr_ctrl #(
   parameter int BURST_LEN = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   sbr_link_if.ctrl link,
   input wire logic req_valid_in,
   input wire sbr_pkg::sbr_cmd_t req_cmd_in,
   input wire logic [1:0] req_bank_in,
   input wire logic [sbr_pkg::ROW_W-1:0] req_addr_in,
   input wire logic req_auto_pre_in,
   output logic req_ready_out,
   output logic req_err_out,
   output logic [3:0] bank_open_out,
   output logic refreshing_out,
   output logic asleep_out
);
   localparam int RW = sbr_pkg::ROW_W;
   localparam int CW = sbr_pkg::CNT_W;
   localparam int FW = sbr_pkg::REFI_W;

   typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_SELF, ST_DEEP} sbr_cst_t;

   sbr_cst_t st_r, st_nxt;
   logic [1:0] div_r, div_nxt;
   logic sck_r, sck_nxt;
   logic cke_r, cke_nxt;
   logic cs_n_r;
   logic [2:0] pat_r, pat_nxt;
   logic [1:0] ba_r, ba_nxt;
   logic [RW-1:0] addr_r, addr_nxt;
   logic [3:0] open_r, open_nxt;
   logic [RW-1:0] row_r [4];
   logic [RW-1:0] row_nxt [4];
   logic [CW-1:0] trc_r [4];
   logic [CW-1:0] trc_nxt [4];
   logic [CW-1:0] rcd_r [4];
   logic [CW-1:0] rcd_nxt [4];
   logic [CW-1:0] tpre_r [4];
   logic [CW-1:0] tpre_nxt [4];
   logic [CW-1:0] rrd_r, rrd_nxt;
   logic [CW-1:0] wait_r, wait_nxt;
   logic [FW-1:0] refi_r, refi_nxt;
   logic err_r, err_nxt;
   logic tick, ok, bad, pre_idle, take;
   logic [1:0] b;

   // Pins change on the link clock's falling edge, centred for the rising sample
   assign tick = (div_r == 2'(sbr_pkg::LINK_HALF - 1)) && sck_r;
   assign b = req_bank_in;

   // Legality and timing of the offered request
   always_comb begin
      pre_idle = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (tpre_r[i] != '0 || trc_r[i] != '0) begin
            pre_idle = 1'b0;
         end
      end
      ok = 1'b0;
      bad = 1'b0;
      case (req_cmd_in)
         sbr_pkg::CMD_ACT: begin
            bad = open_r[b];
            ok = (tpre_r[b] == '0) && (trc_r[b] == '0) && (rrd_r == '0);
         end
         sbr_pkg::CMD_RD, sbr_pkg::CMD_WR: begin
            bad = !open_r[b];
            ok = (rcd_r[b] == '0);
         end
         sbr_pkg::CMD_PRE: ok = (tpre_r[b] == '0);
         sbr_pkg::CMD_PREALL: ok = pre_idle;
         sbr_pkg::CMD_STOP, sbr_pkg::CMD_NOP: ok = 1'b1;
         sbr_pkg::CMD_SELF, sbr_pkg::CMD_DEEP: begin
            bad = (open_r != 4'h0);
            ok = pre_idle;
         end
         default: bad = 1'b1;
      endcase
      // Asleep, only a wake is meaningful, and not before the least stay
      if (st_r == ST_SELF || st_r == ST_DEEP) begin
         bad = (req_cmd_in != sbr_pkg::CMD_WAKE);
         ok = (wait_r == '0);
      end
      req_ready_out = tick && (ok || bad) &&
         ((st_r == ST_RUN && refi_r != '0) || st_r == ST_SELF || st_r == ST_DEEP);
   end

   assign take = req_valid_in && req_ready_out;

   // Next state of the link, bank record and timers
   always_comb begin
      st_nxt = st_r;
      div_nxt = div_r + 2'h1;
      sck_nxt = sck_r;
      cke_nxt = cke_r;
      pat_nxt = pat_r;
      ba_nxt = ba_r;
      addr_nxt = addr_r;
      open_nxt = open_r;
      row_nxt = row_r;
      trc_nxt = trc_r;
      rcd_nxt = rcd_r;
      tpre_nxt = tpre_r;
      rrd_nxt = rrd_r;
      wait_nxt = wait_r;
      refi_nxt = (refi_r == '0) ? refi_r : refi_r - FW'(1);
      err_nxt = 1'b0;
      if (div_r == 2'(sbr_pkg::LINK_HALF - 1)) begin
         div_nxt = 2'h0;
         sck_nxt = ~sck_r;
      end
      if (tick) begin
         pat_nxt = sbr_pkg::PAT_NOP;
         for (int i = 0; i < 4; i++) begin
            trc_nxt[i] = (trc_r[i] == '0) ? trc_r[i] : trc_r[i] - CW'(1);
            rcd_nxt[i] = (rcd_r[i] == '0) ? rcd_r[i] : rcd_r[i] - CW'(1);
            tpre_nxt[i] = (tpre_r[i] == '0) ? tpre_r[i] : tpre_r[i] - CW'(1);
         end
         rrd_nxt = (rrd_r == '0) ? rrd_r : rrd_r - CW'(1);
         wait_nxt = (wait_r == '0) ? wait_r : wait_r - CW'(1);
         if (take && bad) begin
            err_nxt = 1'b1;
         end else if (take) begin
            ba_nxt = b;
            unique case (req_cmd_in)
               sbr_pkg::CMD_ACT: begin
                  pat_nxt = sbr_pkg::PAT_ACT;
                  addr_nxt = req_addr_in;
                  open_nxt[b] = 1'b1;
                  row_nxt[b] = req_addr_in;
                  trc_nxt[b] = sbr_pkg::ROW_CYC_CK;
                  rcd_nxt[b] = sbr_pkg::ROW_COL_CK;
                  rrd_nxt = sbr_pkg::ROW_ROW_CK;
               end
               sbr_pkg::CMD_RD, sbr_pkg::CMD_WR: begin
                  pat_nxt = (req_cmd_in == sbr_pkg::CMD_RD) ? sbr_pkg::PAT_RD : sbr_pkg::PAT_WR;
                  addr_nxt = req_addr_in;
                  addr_nxt[sbr_pkg::PSEL_BIT] = req_auto_pre_in;
                  if (req_auto_pre_in) begin
                     // Bank stays fenced for the burst plus a full precharge
                     open_nxt[b] = 1'b0;
                     tpre_nxt[b] = CW'(BURST_LEN) + sbr_pkg::ROW_PRE_CK;
                  end
               end
               sbr_pkg::CMD_PRE: begin
                  pat_nxt = sbr_pkg::PAT_PRE;
                  addr_nxt[sbr_pkg::PSEL_BIT] = 1'b0;
                  open_nxt[b] = 1'b0;
                  tpre_nxt[b] = sbr_pkg::ROW_PRE_CK;
               end
               sbr_pkg::CMD_PREALL: begin
                  pat_nxt = sbr_pkg::PAT_PRE;
                  addr_nxt[sbr_pkg::PSEL_BIT] = 1'b1;
                  open_nxt = 4'h0;
                  for (int i = 0; i < 4; i++) begin
                     tpre_nxt[i] = sbr_pkg::ROW_PRE_CK;
                  end
               end
               sbr_pkg::CMD_STOP: pat_nxt = sbr_pkg::PAT_STOP;
               sbr_pkg::CMD_SELF: begin
                  pat_nxt = sbr_pkg::PAT_REF;
                  cke_nxt = 1'b0;
                  wait_nxt = sbr_pkg::ROW_ACT_CK;
                  st_nxt = ST_SELF;
               end
               sbr_pkg::CMD_DEEP: begin
                  pat_nxt = sbr_pkg::PAT_STOP;
                  cke_nxt = 1'b0;
                  st_nxt = ST_DEEP;
               end
               sbr_pkg::CMD_WAKE: begin
                  // Link clock never stops, so it is stable before enable rises
                  cke_nxt = 1'b1;
                  wait_nxt = sbr_pkg::SR_EXIT_CK;
                  refi_nxt = sbr_pkg::REFI_CYC;
                  st_nxt = (st_r == ST_SELF) ? ST_WAIT : ST_RUN;
               end
               default: begin
               end
            endcase
         end else begin
            unique case (st_r)
               ST_RUN: begin
                  // Refresh due: close banks, honour precharge time, then refresh
                  if (refi_r == '0 && open_r != 4'h0 && pre_idle) begin
                     pat_nxt = sbr_pkg::PAT_PRE;
                     addr_nxt[sbr_pkg::PSEL_BIT] = 1'b1;
                     open_nxt = 4'h0;
                     for (int i = 0; i < 4; i++) begin
                        tpre_nxt[i] = sbr_pkg::ROW_PRE_CK;
                     end
                  end else if (refi_r == '0 && open_r == 4'h0 && pre_idle) begin
                     pat_nxt = sbr_pkg::PAT_REF;
                     wait_nxt = sbr_pkg::REF_CYC_CK;
                     refi_nxt = sbr_pkg::REFI_CYC;
                     st_nxt = ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  if (wait_r == '0) begin
                     st_nxt = ST_RUN;
                  end
               end
               ST_SELF, ST_DEEP: begin
                  refi_nxt = sbr_pkg::REFI_CYC;
               end
            endcase
         end
      end
   end

   // State registers; pins idle deselected with enable high under reset
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_r <= ST_RUN;
         div_r <= 2'h0;
         sck_r <= 1'b0;
         cke_r <= 1'b1;
         cs_n_r <= 1'b1;
         pat_r <= sbr_pkg::PAT_NOP;
         ba_r <= 2'h0;
         addr_r <= '0;
         open_r <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            row_r[i] <= '0;
            trc_r[i] <= '0;
            rcd_r[i] <= '0;
            tpre_r[i] <= '0;
         end
         rrd_r <= '0;
         wait_r <= '0;
         refi_r <= sbr_pkg::REFI_CYC;
         err_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         sck_r <= sck_nxt;
         cke_r <= cke_nxt;
         cs_n_r <= 1'b0;
         pat_r <= pat_nxt;
         ba_r <= ba_nxt;
         addr_r <= addr_nxt;
         open_r <= open_nxt;
         row_r <= row_nxt;
         trc_r <= trc_nxt;
         rcd_r <= rcd_nxt;
         tpre_r <= tpre_nxt;
         rrd_r <= rrd_nxt;
         wait_r <= wait_nxt;
         refi_r <= refi_nxt;
         err_r <= err_nxt;
      end
   end

   // Link pins, all from flops
   assign link.sdram_clk = sck_r;
   assign link.cke = cke_r;
   assign link.cs_n = cs_n_r;
   assign {link.ras_n, link.cas_n, link.we_n} = pat_r;
   assign link.ba = ba_r;
   assign link.addr = addr_r;

   assign req_err_out = err_r;
   assign bank_open_out = open_r;
   assign refreshing_out = (st_r == ST_WAIT);
   assign asleep_out = (st_r == ST_SELF) || (st_r == ST_DEEP);
endmodule
`default_nettype wire

// file: test/sbr_link_properties.sv
// Wire-level checks on the SDRAM command link
`timescale 1ns/1ps
`default_nettype none
module sbr_link_properties #(
   parameter int BURST_LEN = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sdram_clk,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [sbr_pkg::ROW_W-1:0] addr
);
   logic sck_r;
   logic cmd;
   logic [2:0] pat;
   logic [3:0] open_r;
   logic [3:0] open_nxt;
   logic [5:0] ap_r;
   logic [5:0] ap_nxt;
   logic [1:0] apb_r;
   logic [1:0] apb_nxt;

   // A command is launched with the falling link edge, so look only then
   assign pat = {ras_n, cas_n, we_n};
   assign cmd = sck_r && !sdram_clk && !cs_n && cke;

   // Open banks and auto precharge fence as seen on the wire alone
   always_comb begin
      open_nxt = open_r;
      ap_nxt = (ap_r != 6'h00) ? ap_r - 6'h01 : ap_r;
      apb_nxt = apb_r;
      if (cmd && pat == sbr_pkg::PAT_ACT) begin
         open_nxt[ba] = 1'b1;
      end else if (cmd && pat == sbr_pkg::PAT_PRE && addr[sbr_pkg::PSEL_BIT]) begin
         open_nxt = 4'h0;
      end else if (cmd && pat == sbr_pkg::PAT_PRE) begin
         open_nxt[ba] = 1'b0;
      end else if (cmd && pat[2:1] == 2'h2 && addr[sbr_pkg::PSEL_BIT]) begin
         open_nxt[ba] = 1'b0;
         ap_nxt = 6'((BURST_LEN + 1) * 2 * sbr_pkg::LINK_HALF - 1);
         apb_nxt = ba;
      end
   end

   // Registers only
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sck_r <= 1'b0;
         open_r <= 4'h0;
         ap_r <= 6'h00;
         apb_r <= 2'h0;
      end else begin
         sck_r <= sdram_clk;
         open_r <= open_nxt;
         ap_r <= ap_nxt;
         apb_r <= apb_nxt;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   AST_LINK_PERIOD: assert property ($rose(sdram_clk) |-> ##8 $rose(sdram_clk))
      else $error("link clock period wrong");
   AST_PINS_AT_FALL: assert property (!$stable({cke, pat, ba, addr}) |-> $fell(sdram_clk))
      else $error("pins changed away from falling link edge");
   AST_REF_IDLE: assert property (cmd && pat == sbr_pkg::PAT_REF |-> open_r == 4'h0)
      else $error("refresh with a bank open");
   AST_SLEEP_PAT: assert property ($fell(cke) |-> !cs_n && pat inside {3'h1, 3'h6})
      else $error("clock enable dropped without entry pattern");
   AST_SLEEP_IDLE: assert property ($fell(cke) |-> open_r == 4'h0)
      else $error("low power entry with a bank open");
   AST_SLEEP_MIN: assert property ($fell(cke) |-> (!cke) [*8])
      else $error("low power left too early");
   AST_EXIT_NOP: assert property ($rose(cke) |-> (pat == sbr_pkg::PAT_NOP) [*8])
      else $error("command during exit wait");
   AST_ACCESS_OPEN: assert property (cmd && pat[2:1] == 2'h2 |-> open_r[ba])
      else $error("access to an idle bank");
   AST_ACT_IDLE: assert property (cmd && pat == sbr_pkg::PAT_ACT |-> !open_r[ba])
      else $error("activate to an open bank");
   AST_AP_FENCE: assert property (ap_r != 6'h00 && cmd && pat != 3'h1 && pat != 3'h6 && pat != 3'h7
      |-> ba != apb_r)
      else $error("command inside auto precharge fence");
endmodule
`default_nettype wire

// file: test/tb_sdram_bank_refresh_control.sv
// Controller and SDRAM ends joined by the link, driven through requests
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_bank_refresh_control;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic req_valid_in = 1'b0;
   sbr_pkg::sbr_cmd_t req_cmd_in = sbr_pkg::CMD_NOP;
   logic [1:0] req_bank_in = 2'h0;
   logic [12:0] req_addr_in = 13'h0;
   logic req_auto_pre_in = 1'b0;
   logic ready, err, refr, asleep, cut, sref, deep, lost;
   logic [3:0] copen;
   logic [3:0] mopen;
   logic [12:0] row;
   logic [12:0] row0;
   int err_count = 0;
   int checks_done = 0;
   int cuts = 0;
   sbr_link_if link ();

   sbr_ctrl #(.BURST_LEN(4)) u_sbr_ctrl (.clk_in(clk_in), .rst_in(rst_in), .link(link),
      .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
      .req_addr_in(req_addr_in), .req_auto_pre_in(req_auto_pre_in), .req_ready_out(ready),
      .req_err_out(err), .bank_open_out(copen), .refreshing_out(refr), .asleep_out(asleep));
   sbr_mem #(.BURST_LEN(4), .SR_OSC_CYC(8)) u_sbr_mem (.clk_in(clk_in), .rst_in(rst_in),
      .link(link), .bank_open_out(mopen), .burst_active_out(), .burst_cut_out(cut),
      .ref_row_out(row), .self_ref_out(sref), .deep_pd_out(deep), .data_lost_out(lost));
   sbr_link_properties #(.BURST_LEN(4)) u_sbr_link_properties (.clk_in(clk_in),
      .rst_in(rst_in), .sdram_clk(link.sdram_clk), .cke(link.cke), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr));

   // 100 MHz clock; cut pulses last one cycle, so count them here
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) if (cut === 1'b1) cuts <= cuts + 1;

   // Verdict
   task automatic complete_run();
      $display("Checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Compare
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One request, held until taken at a ready edge; error flag follows a cycle later
   task automatic issue(input sbr_pkg::sbr_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                        input logic ap, input logic exp_err);
      int n;
      n = 0;
      req_cmd_in <= c;
      req_bank_in <= b;
      req_addr_in <= a;
      req_auto_pre_in <= ap;
      req_valid_in <= 1'b1;
      do begin
         @(negedge clk_in);
         n++;
      end while (ready !== 1'b1 && n < 2000);
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      @(negedge clk_in);
      if (n >= 2000) begin
         err_count++;
         complete_run();
      end
      check("req_err", 16'(err), 16'(exp_err));
      @(posedge clk_in);
   endtask

   // Waits whole link clocks
   task automatic ticks(input int n);
      repeat (n * 2 * sbr_pkg::LINK_HALF) @(posedge clk_in);
   endtask

   // Waits until a refresh has run, so the next stretch is free of refresh
   task automatic sync_ref();
      int n;
      logic hi;
      n = 0;
      hi = 1'b0;
      do begin
         @(negedge clk_in);
         hi = hi || (refr === 1'b1);
         n++;
      end while (!(hi && refr === 1'b0) && n < 2000);
      if (n >= 2000) begin
         err_count++;
         complete_run();
      end
      ticks(1);
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      sync_ref();
      issue(sbr_pkg::CMD_RD, 2'h0, 13'h0, 1'h0, 1'h1);
      issue(sbr_pkg::CMD_ACT, 2'h1, 13'h5, 1'h0, 1'h0);
      issue(sbr_pkg::CMD_ACT, 2'h1, 13'h6, 1'h0, 1'h1);
      issue(sbr_pkg::CMD_ACT, 2'h2, 13'h7, 1'h0, 1'h0);
      issue(sbr_pkg::CMD_RD, 2'h1, 13'h0, 1'h0, 1'h0);
      issue(sbr_pkg::CMD_STOP, 2'h0, 13'h0, 1'h0, 1'h0);
      ticks(2);
      check("cuts", 16'(cuts), 16'h1);
      check("ctrl_open", 16'(copen), 16'h6);
      check("mem_open", 16'(mopen), 16'h6);
      issue(sbr_pkg::CMD_PRE, 2'h2, 13'h0, 1'h0, 1'h0);
      ticks(2);
      check("mem_open", 16'(mopen), 16'h2);
      sync_ref();
      issue(sbr_pkg::CMD_ACT, 2'h1, 13'h5, 1'h0, 1'h0);
      issue(sbr_pkg::CMD_WR, 2'h1, 13'h8, 1'h1, 1'h0);
      ticks(6);
      check("mem_open", 16'(mopen), 16'h0);
      issue(sbr_pkg::CMD_RD, 2'h1, 13'h0, 1'h0, 1'h1);
      issue(sbr_pkg::CMD_ACT, 2'h1, 13'h9, 1'h0, 1'h0);
      issue(sbr_pkg::CMD_RD, 2'h1, 13'h0, 1'h0, 1'h0);
      ticks(6);
      check("mem_open", 16'(mopen), 16'h2);
      issue(sbr_pkg::CMD_PREALL, 2'h2, 13'h0, 1'h0, 1'h0);
      ticks(2);
      check("mem_open", 16'(mopen), 16'h0);
      issue(sbr_pkg::CMD_ACT, 2'h3, 13'h9, 1'h0, 1'h0);
      row0 = row;
      sync_ref();
      check("ref_row", 16'(row), 16'(row0 + 13'h1));
      check("mem_open", 16'(mopen), 16'h0);
      issue(sbr_pkg::CMD_SELF, 2'h0, 13'h0, 1'h0, 1'h0);
      ticks(2);
      row0 = row;
      check("self_ref", 16'(sref), 16'h1);
      issue(sbr_pkg::CMD_ACT, 2'h0, 13'h1, 1'h0, 1'h1);
      ticks(8);
      check("sr_rows", 16'(row - row0 >= 13'h4), 16'h1);
      issue(sbr_pkg::CMD_WAKE, 2'h0, 13'h0, 1'h0, 1'h0);
      ticks(3);
      check("self_ref", 16'(sref), 16'h0);
      check("asleep", 16'(asleep), 16'h0);
      issue(sbr_pkg::CMD_ACT, 2'h0, 13'h1, 1'h0, 1'h0);
      issue(sbr_pkg::CMD_DEEP, 2'h0, 13'h0, 1'h0, 1'h1);
      issue(sbr_pkg::CMD_PREALL, 2'h0, 13'h0, 1'h0, 1'h0);
      issue(sbr_pkg::CMD_DEEP, 2'h0, 13'h0, 1'h0, 1'h0);
      ticks(2);
      check("deep", 16'(deep), 16'h1);
      check("lost", 16'(lost), 16'h1);
      issue(sbr_pkg::CMD_WAKE, 2'h0, 13'h0, 1'h0, 1'h0);
      ticks(2);
      check("deep", 16'(deep), 16'h0);
      complete_run();
   end
endmodule
`default_nettype wire
